//--- logic/rcal_map.svh
// Purpose: offsets, field positions, codes and reset values of the clock block
// Assumes: 32-bit APB data, one aligned word per register
// Notes: definitions only
`ifndef RCAL_MAP_SVH
`define RCAL_MAP_SVH
`define RCAL_OFS_CTRL 8'h00
`define RCAL_OFS_ALRM 8'h04
`define RCAL_OFS_CLK 8'h08
`define RCAL_OFS_DIV 8'h0C
`define RCAL_OFS_WIN 8'h10
`define RCAL_OFS_TIME 8'h14
`define RCAL_OFS_DATE 8'h18
`define RCAL_OFS_ATIME 8'h1C
`define RCAL_OFS_ADATE 8'h20
`define RCAL_OFS_STAT 8'h24
`define RCAL_CTRL_EN 15
`define RCAL_CTRL_POWER_CTL_ENABLE 10
`define RCAL_CTRL_POL 9
`define RCAL_CTRL_OE 7
`define RCAL_CTRL_SEL 4
`define RCAL_ALRM_EN 15
`define RCAL_ALRM_CHIME 14
`define RCAL_ALRM_MASK 8
`define RCAL_CLK_FDIV 11
`define RCAL_CLK_PWCPS 6
`define RCAL_CLK_PS 4
`define RCAL_SRC_SECONDARY_CRYSTAL_OSC 2'h0
`define RCAL_SRC_LOW_POWER_RC_OSC 2'h1
`define RCAL_SRC_LINE 2'h2
`define RCAL_SRC_SYS 2'h3
`define RCAL_OUT_ALARM 3'h0
`define RCAL_OUT_SEC 3'h1
`define RCAL_OUT_REF 3'h2
`define RCAL_OUT_PWC 3'h3
`define RCAL_RST_DIV 16'h3FFF
`define RCAL_RST_TIME 24'h00_0000
`define RCAL_RST_DATE 32'h0001_0106
`define RCAL_WIN_ALWAYS 8'hFF
`define RCAL_RPT_WRAP 8'hFF
`endif

//--- logic/rcal_pkg.sv
// Purpose: shared types and prescale decode of the clock block
// Assumes: nothing
// Notes: BCD fields throughout
package rcal_pkg;
  typedef struct packed {
    logic [7:0] hr;
    logic [7:0] mn;
    logic [7:0] sc;
  } rcal_time_t;
  typedef struct packed {
    logic [7:0] yr;
    logic [7:0] mo;
    logic [7:0] dy;
    logic [7:0] wd;
  } rcal_date_t;
  typedef enum logic [2:0] {
    PWC_IDLE = 3'b001,
    PWC_STAB = 3'b010,
    PWC_SAMP = 3'b100
  } rcal_pwc_t;
  // Terminal count of a 1/16/64/256 or 1/1 prescaler
  function automatic logic rcal_ratio_hit(logic [7:0] cnt, logic [1:0] sel, logic one_is_unity);
    case (sel)
      2'h0: rcal_ratio_hit = one_is_unity ? 1'b1 : (cnt[3:0] == 4'hF);
      2'h1: rcal_ratio_hit = one_is_unity ? (cnt[3:0] == 4'hF) : (cnt[5:0] == 6'h3F);
      2'h2: rcal_ratio_hit = one_is_unity ? (cnt[5:0] == 6'h3F) : (&cnt);
      default: rcal_ratio_hit = &cnt;
    endcase
  endfunction
endpackage

//--- logic/rcal_divider.sv
// Purpose: async prescaler, coarse and fine divider to a half-second tick
// Assumes: ref_edge is a one-cycle pulse per reference period
// Notes: fine setting swallows prescaled pulses over 32 half seconds
`timescale 1ns/10ps
module rcal_divider #(
  parameter int DIV_W = 16,
  parameter int FINE_W = 5
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Settings
  input wire logic enable,
  input wire logic ref_edge,
  input wire logic [1:0] async_prescale_select,
  input wire logic [DIV_W-1:0] coarse_div,
  input wire logic [FINE_W-1:0] fine_divide_value,
  // Tick
  output logic half_tick
);
  logic [7:0] ps_cnt_q;
  logic [DIV_W-1:0] div_cnt_q;
  logic [FINE_W-1:0] slot_q;
  logic swallow_q;
  logic ps_tick;
  logic term;

  // Prescaled pulse, ratios 1:16, 1:64, 1:256
  assign ps_tick = enable & ref_edge & rcal_pkg::rcal_ratio_hit(ps_cnt_q, async_prescale_select, 1'b0);
  assign term = ps_tick & ~swallow_q & (div_cnt_q >= coarse_div);

  // Prescaler counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ps_cnt_q <= 8'h00;
    end else if (!enable) begin
      ps_cnt_q <= 8'h00;
    end else if (ref_edge) begin
      ps_cnt_q <= ps_cnt_q + 8'h01;
    end
  end

  // Coarse counter spans setting plus one pulses
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt_q <= '0;
    end else if (!enable) begin
      div_cnt_q <= '0;
    end else if (term) begin
      div_cnt_q <= '0;
    end else if (ps_tick && !swallow_q) begin
      div_cnt_q <= div_cnt_q + 1'b1;
    end
  end

  // Fine slot and pulse removal, longer period for larger fine value
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slot_q <= '0;
      swallow_q <= 1'b0;
    end else if (!enable) begin
      slot_q <= '0;
      swallow_q <= 1'b0;
    end else if (term) begin
      slot_q <= slot_q + 1'b1;
      swallow_q <= (slot_q < fine_divide_value);
    end else if (ps_tick) begin
      swallow_q <= 1'b0;
    end
  end

  // Registered tick
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      half_tick <= 1'b0;
    end else begin
      half_tick <= term;
    end
  end

  fine_off_a: assert property (@(posedge pclk) disable iff (!presetn)
    (term && fine_divide_value == '0) |=> !swallow_q)
    else $error("pulse removed with fine setting zero");
  tick_src_a: assert property (@(posedge pclk) disable iff (!presetn)
    half_tick |-> $past(ps_tick) && $past(div_cnt_q >= coarse_div))
    else $error("tick without coarse terminal count");
endmodule

//--- logic/rcal_calendar.sv
// Purpose: BCD time of day and calendar, years 2000 to 2099
// Assumes: half_tick is a one-cycle pulse
// Notes: software loads win over a tick in the same cycle
`timescale 1ns/10ps
`include "rcal_map.svh"
module rcal_calendar (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Tick and loads
  input wire logic half_tick,
  input wire logic load_time,
  input wire logic load_date,
  input wire logic [31:0] wdata,
  // State
  output rcal_pkg::rcal_time_t time_q,
  output rcal_pkg::rcal_date_t date_q,
  output logic half_q
);
  // BCD increment of one byte
  function automatic logic [7:0] bcd_inc(logic [7:0] v);
    bcd_inc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : {v[7:4], v[3:0] + 4'h1};
  endfunction
  // Last day of month with leap years
  function automatic logic [7:0] last_day(logic [7:0] mo, logic [7:0] yr);
    logic leap;
    leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
                 : (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
    case (mo)
      8'h02: last_day = leap ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: last_day = 8'h30;
      default: last_day = 8'h31;
    endcase
  endfunction

  logic sec_step;
  assign sec_step = half_tick & half_q;

  // Half-second phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      half_q <= 1'b0;
    end else if (load_time) begin
      half_q <= 1'b0;
    end else if (half_tick) begin
      half_q <= ~half_q;
    end
  end

  // Time of day, 24-hour rollover
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      time_q <= `RCAL_RST_TIME;
    end else if (load_time) begin
      time_q <= wdata[23:0];
    end else if (sec_step) begin
      time_q.sc <= (time_q.sc == 8'h59) ? 8'h00 : bcd_inc(time_q.sc);
      if (time_q.sc == 8'h59) begin
        time_q.mn <= (time_q.mn == 8'h59) ? 8'h00 : bcd_inc(time_q.mn);
        if (time_q.mn == 8'h59) begin
          time_q.hr <= (time_q.hr == 8'h23) ? 8'h00 : bcd_inc(time_q.hr);
        end
      end
    end
  end

  // Calendar advances at midnight
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      date_q <= `RCAL_RST_DATE;
    end else if (load_date) begin
      date_q <= wdata;
    end else if (sec_step && time_q == 24'h23_5959) begin
      date_q.wd <= (date_q.wd == 8'h06) ? 8'h00 : bcd_inc(date_q.wd);
      if (date_q.dy == last_day(date_q.mo, date_q.yr)) begin
        date_q.dy <= 8'h01;
        date_q.mo <= (date_q.mo == 8'h12) ? 8'h01 : bcd_inc(date_q.mo);
        if (date_q.mo == 8'h12) begin
          date_q.yr <= (date_q.yr == 8'h99) ? 8'h00 : bcd_inc(date_q.yr);
        end
      end else begin
        date_q.dy <= bcd_inc(date_q.dy);
      end
    end
  end

  sec_bcd_a: assert property (@(posedge pclk) disable iff (!presetn)
    (sec_step && !load_time && time_q.sc == 8'h59) |=> time_q.sc == 8'h00)
    else $error("seconds did not roll over");
endmodule

//--- logic/rcal_rtc_calendar.sv
// Purpose: real-time clock with alarm and power control sequencer, APB slave
// Assumes: reference inputs synchronous to pclk; pclk 40 MHz
// Notes: zero-wait APB; read data sampled in the setup cycle
// Operation
// - two-bit select picks crystal, RC, power line or system clock reference
// - asynchronous prescaler offers 1:16, 1:64 and 1:256
// - 16-bit counter period is divide setting plus one prescaled pulses
// - tick rate follows input over prescale times divide plus one plus fine/32
// - fine zero removes nothing; otherwise up to 31 pulses per 16 seconds
// - larger fine setting gives longer divider period
// - coarse and fine settings act as one 21-bit value, fine lowest
// - calendar counts 2000 to 2099 with leap years, weekday, date, month
// - 24-hour time, all fields BCD
// - hardware clears alarm enable on last alarm without chime
// - four-bit mask picks alarm interval half second up to year
// - repeat count decrements on each alarm while nonzero
// - alarm at count zero without chime is the last one
// - with chime the count wraps from zero to FFh
// - every alarm gives a one-cycle event usable as trigger
// - control output reaches pin only when enabled with select 011
// - polarity bit sets control output active level
// - control on opens stability window, then sample gate, then all close
// - power control cycle runs without processor help
// - window lengths are 8-bit counts of power-control clock periods
// - power-control clock prescaler offers 1:1, 1:16, 1:64, 1:256
// - window length 00h disables it; stability FFh holds it always on
`timescale 1ns/10ps
`include "rcal_map.svh"
module rcal_rtc_calendar #(
  parameter int ADDR_W = 8
) (
  // APB slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Reference clock sources
  input wire logic secondary_crystal_osc,
  input wire logic low_power_rc_osc,
  input wire logic power_line_clk,
  // Pin and events
  output logic rtc_pin,
  output logic rtc_pin_en,
  output logic alarm_event,
  output logic sample_gate
);
  logic [15:0] ctrl_q;
  logic [15:0] alrm_q;
  logic [15:0] clk_q;
  logic [15:0] div_q;
  logic [15:0] win_q;
  rcal_pkg::rcal_time_t atime_q;
  rcal_pkg::rcal_date_t adate_q;
  rcal_pkg::rcal_time_t time_q;
  rcal_pkg::rcal_date_t date_q;
  rcal_pkg::rcal_pwc_t pwc_q;
  logic half_q;
  logic half_tick;
  logic chk_q;
  logic ref_prev_q;
  logic [7:0] pwc_cnt_q;
  logic [7:0] wcnt_q;
  logic [31:0] rd;
  logic hit;
  logic wr;
  logic ref_lvl;
  logic ref_edge;
  logic match;
  logic fire;
  logic pwc_tick;
  logic ctrl_active;
  logic pin_d;

  logic module_enable;
  logic power_ctl_enable;
  logic power_ctl_polarity;
  logic clock_pin_output_enable;
  logic [2:0] pin_output_select;
  logic alarm_enable;
  logic chime;
  logic [3:0] alarm_interval_mask;
  logic [7:0] alarm_repeat_count;
  logic [1:0] ref_clock_select;
  logic [1:0] async_prescale_select;
  logic [1:0] power_ctl_clk_prescale;
  logic [4:0] fine_divide_value;
  logic [7:0] stability_window_len;
  logic [7:0] sample_window_len;

  // Field views of the control words
  assign module_enable = ctrl_q[`RCAL_CTRL_EN];
  assign power_ctl_enable = ctrl_q[`RCAL_CTRL_POWER_CTL_ENABLE];
  assign power_ctl_polarity = ctrl_q[`RCAL_CTRL_POL];
  assign clock_pin_output_enable = ctrl_q[`RCAL_CTRL_OE];
  assign pin_output_select = ctrl_q[`RCAL_CTRL_SEL +: 3];
  assign alarm_enable = alrm_q[`RCAL_ALRM_EN];
  assign chime = alrm_q[`RCAL_ALRM_CHIME];
  assign alarm_interval_mask = alrm_q[`RCAL_ALRM_MASK +: 4];
  assign alarm_repeat_count = alrm_q[7:0];
  assign ref_clock_select = clk_q[1:0];
  assign async_prescale_select = clk_q[`RCAL_CLK_PS +: 2];
  assign power_ctl_clk_prescale = clk_q[`RCAL_CLK_PWCPS +: 2];
  assign fine_divide_value = clk_q[`RCAL_CLK_FDIV +: 5];
  assign stability_window_len = win_q[7:0];
  assign sample_window_len = win_q[15:8];

  // APB handshake: zero wait, error on unmapped address
  assign wr = psel & penable & pwrite;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~hit;

  // Read mux and address decode
  always_comb begin
    hit = 1'b1;
    rd = 32'h0000_0000;
    case (paddr)
      `RCAL_OFS_CTRL: rd = {16'h0000, ctrl_q};
      `RCAL_OFS_ALRM: rd = {16'h0000, alrm_q};
      `RCAL_OFS_CLK: rd = {16'h0000, clk_q};
      `RCAL_OFS_DIV: rd = {16'h0000, div_q};
      `RCAL_OFS_WIN: rd = {16'h0000, win_q};
      `RCAL_OFS_TIME: rd = {8'h00, time_q};
      `RCAL_OFS_DATE: rd = date_q;
      `RCAL_OFS_ATIME: rd = {8'h00, atime_q};
      `RCAL_OFS_ADATE: rd = adate_q;
      `RCAL_OFS_STAT: rd = {26'h000_0000, pwc_q, sample_gate, ctrl_active, half_q};
      default: hit = 1'b0;
    endcase
  end

  // Read data captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rd;
    end
  end

  // Plain configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= 16'h0000;
      clk_q <= 16'h0000;
      div_q <= `RCAL_RST_DIV;
      win_q <= 16'h0000;
      atime_q <= `RCAL_RST_TIME;
      adate_q <= `RCAL_RST_DATE;
    end else if (wr) begin
      if (paddr == `RCAL_OFS_CTRL) ctrl_q <= pwdata[15:0] & 16'h86F0;
      if (paddr == `RCAL_OFS_CLK) clk_q <= pwdata[15:0] & 16'hF8F3;
      if (paddr == `RCAL_OFS_DIV) div_q <= pwdata[15:0];
      if (paddr == `RCAL_OFS_WIN) win_q <= pwdata[15:0];
      if (paddr == `RCAL_OFS_ATIME) atime_q <= pwdata[23:0];
      if (paddr == `RCAL_OFS_ADATE) adate_q <= pwdata;
    end
  end

  // Alarm control: software write, else count and auto-disable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alrm_q <= 16'h0000;
    end else if (wr && paddr == `RCAL_OFS_ALRM) begin
      alrm_q <= pwdata[15:0] & 16'hCFFF;
    end else if (fire) begin
      if (alarm_repeat_count != 8'h00) begin
        alrm_q[7:0] <= alarm_repeat_count - 8'h01;
      end else if (chime) begin
        alrm_q[7:0] <= `RCAL_RPT_WRAP;
      end else begin
        alrm_q[`RCAL_ALRM_EN] <= 1'b0;
      end
    end
  end

  // Reference source select and edge detect
  always_comb begin
    case (ref_clock_select)
      `RCAL_SRC_SECONDARY_CRYSTAL_OSC: ref_lvl = secondary_crystal_osc;
      `RCAL_SRC_LOW_POWER_RC_OSC: ref_lvl = low_power_rc_osc;
      `RCAL_SRC_LINE: ref_lvl = power_line_clk;
      default: ref_lvl = pclk_ref_level();
    endcase
  end
  function automatic logic pclk_ref_level();
    pclk_ref_level = 1'b1;
  endfunction
  assign ref_edge = (ref_clock_select == `RCAL_SRC_SYS) | (ref_lvl & ~ref_prev_q);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_prev_q <= 1'b0;
    end else begin
      ref_prev_q <= ref_lvl;
    end
  end

  // Divider and calendar
  rcal_divider #(
    .DIV_W(16),
    .FINE_W(5)
  ) u_div (
    .pclk(pclk),
    .presetn(presetn),
    .enable(module_enable),
    .ref_edge(ref_edge),
    .async_prescale_select(async_prescale_select),
    .coarse_div(div_q),
    .fine_divide_value(fine_divide_value),
    .half_tick(half_tick)
  );

  rcal_calendar u_cal (
    .pclk(pclk),
    .presetn(presetn),
    .half_tick(half_tick),
    .load_time(wr && paddr == `RCAL_OFS_TIME),
    .load_date(wr && paddr == `RCAL_OFS_DATE),
    .wdata(pwdata),
    .time_q(time_q),
    .date_q(date_q),
    .half_q(half_q)
  );

  // Alarm compare on the cycle after the calendar moves
  always_comb begin
    logic s_u;
    logic s_a;
    logic m_u;
    logic m_a;
    logic h_a;
    s_u = (time_q.sc[3:0] == atime_q.sc[3:0]);
    s_a = (time_q.sc == atime_q.sc);
    m_u = (time_q.mn[3:0] == atime_q.mn[3:0]);
    m_a = (time_q.mn == atime_q.mn);
    h_a = (time_q.hr == atime_q.hr);
    case (alarm_interval_mask)
      4'h0: match = 1'b1;
      4'h1: match = !half_q;
      4'h2: match = !half_q && s_u;
      4'h3: match = !half_q && s_a;
      4'h4: match = !half_q && s_a && m_u;
      4'h5: match = !half_q && s_a && m_a;
      4'h6: match = !half_q && s_a && m_a && h_a;
      4'h7: match = !half_q && s_a && m_a && h_a && (date_q.wd == adate_q.wd);
      4'h8: match = !half_q && s_a && m_a && h_a && (date_q.dy == adate_q.dy);
      4'h9: match = !half_q && s_a && m_a && h_a && (date_q.dy == adate_q.dy) && (date_q.mo == adate_q.mo);
      default: match = 1'b0;
    endcase
  end
  assign fire = chk_q & alarm_enable & match;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chk_q <= 1'b0;
      alarm_event <= 1'b0;
    end else begin
      chk_q <= half_tick;
      alarm_event <= fire;
    end
  end

  // Power-control clock prescaler
  assign pwc_tick = ref_edge & module_enable &
    rcal_pkg::rcal_ratio_hit(pwc_cnt_q, power_ctl_clk_prescale, 1'b1);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwc_cnt_q <= 8'h00;
    end else if (ref_edge) begin
      pwc_cnt_q <= pwc_cnt_q + 8'h01;
    end
  end

  // Power-control sequencer, autonomous once started
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwc_q <= rcal_pkg::PWC_IDLE;
      wcnt_q <= 8'h00;
    end else if (!module_enable) begin
      pwc_q <= rcal_pkg::PWC_IDLE;
      wcnt_q <= 8'h00;
    end else begin
      case (pwc_q)
        rcal_pkg::PWC_IDLE: begin
          wcnt_q <= 8'h00;
          if (alarm_event && power_ctl_enable) begin
            if (stability_window_len != 8'h00) begin
              pwc_q <= rcal_pkg::PWC_STAB;
            end else if (sample_window_len != 8'h00) begin
              pwc_q <= rcal_pkg::PWC_SAMP;
            end
          end
        end
        rcal_pkg::PWC_STAB: begin
          if (pwc_tick && stability_window_len != `RCAL_WIN_ALWAYS) begin
            wcnt_q <= wcnt_q + 8'h01;
            if (wcnt_q + 8'h01 >= stability_window_len) begin
              wcnt_q <= 8'h00;
              pwc_q <= (sample_window_len != 8'h00) ? rcal_pkg::PWC_SAMP : rcal_pkg::PWC_IDLE;
            end
          end
        end
        rcal_pkg::PWC_SAMP: begin
          if (pwc_tick) begin
            wcnt_q <= wcnt_q + 8'h01;
            if (wcnt_q + 8'h01 >= sample_window_len) begin
              pwc_q <= rcal_pkg::PWC_IDLE;
            end
          end
        end
        default: pwc_q <= rcal_pkg::PWC_IDLE;
      endcase
    end
  end

  // Control active in either window, or held by FFh stability
  assign ctrl_active = (pwc_q != rcal_pkg::PWC_IDLE) ||
    (stability_window_len == `RCAL_WIN_ALWAYS);
  assign sample_gate = (pwc_q == rcal_pkg::PWC_SAMP);

  // Pin output select and polarity
  always_comb begin
    case (pin_output_select)
      `RCAL_OUT_ALARM: pin_d = alarm_event;
      `RCAL_OUT_SEC: pin_d = half_q;
      `RCAL_OUT_REF: pin_d = ref_lvl;
      `RCAL_OUT_PWC: pin_d = power_ctl_polarity ? ctrl_active : ~ctrl_active;
      default: pin_d = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rtc_pin <= 1'b0;
      rtc_pin_en <= 1'b0;
    end else begin
      rtc_pin <= clock_pin_output_enable & pin_d;
      rtc_pin_en <= clock_pin_output_enable;
    end
  end

  repeat_dec_a: assert property (@(posedge pclk) disable iff (!presetn)
    (fire && alarm_repeat_count != 8'h00 && !(wr && paddr == `RCAL_OFS_ALRM))
    |=> alarm_repeat_count == $past(alarm_repeat_count) - 8'h01)
    else $error("repeat count did not decrement");
  chime_wrap_a: assert property (@(posedge pclk) disable iff (!presetn)
    (fire && chime && alarm_repeat_count == 8'h00 && !(wr && paddr == `RCAL_OFS_ALRM))
    |=> alarm_repeat_count == 8'hFF && alarm_enable)
    else $error("chime did not wrap count");
  alarm_off_a: assert property (@(posedge pclk) disable iff (!presetn)
    (fire && !chime && alarm_repeat_count == 8'h00 && !(wr && paddr == `RCAL_OFS_ALRM))
    |=> !alarm_enable)
    else $error("last alarm left enable set");
  event_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
    alarm_event |-> $past(chk_q) && $past(alarm_enable) ##1 !alarm_event)
    else $error("alarm event without cause or too long");
  pin_pwc_a: assert property (@(posedge pclk) disable iff (!presetn)
    (clock_pin_output_enable && pin_output_select == 3'h3) |=>
    rtc_pin == ($past(power_ctl_polarity) ? $past(ctrl_active) : !$past(ctrl_active)))
    else $error("power control pin level wrong");
  pwc_start_a: assert property (@(posedge pclk) disable iff (!presetn)
    (alarm_event && power_ctl_enable && module_enable && pwc_q == rcal_pkg::PWC_IDLE &&
     stability_window_len != 8'h00) |=> pwc_q == rcal_pkg::PWC_STAB && ctrl_active)
    else $error("alarm did not start power cycle");
  stab_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    (stability_window_len == 8'hFF && pwc_q == rcal_pkg::PWC_STAB) |=> pwc_q != rcal_pkg::PWC_SAMP)
    else $error("held stability window left");
  gate_order_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(sample_gate) |-> $past(pwc_q) == rcal_pkg::PWC_STAB || $past(stability_window_len) == 8'h00)
    else $error("sample gate opened before stability");
endmodule

//--- verification/rcal_ext_dev.sv
// Purpose: external device powered by the control pin and sampled by the gate
// Assumes: active_high follows the polarity setting
// Notes: fault latches if the gate opens while the device is unpowered
`timescale 1ns/10ps
module rcal_ext_dev (
  // Clock
  input wire logic pclk,
  // Pin and gate
  input wire logic pin,
  input wire logic pin_en,
  input wire logic gate,
  input wire logic active_high,
  // Result
  output logic fault
);
  // Device sees power only while the pin drives its active level
  initial fault = 1'b0;
  always @(posedge pclk) begin
    if (gate && !(pin_en && pin == active_high)) begin
      fault <= 1'b1;
    end
  end
endmodule

//--- verification/rcal_rtc_calendar_bench.sv
// Purpose: register-level tests of the clock, alarm and power sequencer
// Assumes: zero-wait APB slave, pclk as reference
// Notes: divide 0 and prescale 1:16 give a half tick every 16 cycles
`timescale 1ns/10ps
module rcal_rtc_calendar_bench;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pol = 1, xo = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, q;
  logic pready, pslverr, rtc_pin, rtc_pin_en, alarm_event, sample_gate, fault, err;
  int num_errors = 0, checks = 0, n, p, g;
  rcal_rtc_calendar u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .secondary_crystal_osc(xo), .low_power_rc_osc(1'b0),
    .power_line_clk(1'b0), .rtc_pin(rtc_pin), .rtc_pin_en(rtc_pin_en),
    .alarm_event(alarm_event), .sample_gate(sample_gate));
  rcal_ext_dev u_dev (.pclk(pclk), .pin(rtc_pin), .pin_en(rtc_pin_en), .gate(sample_gate),
    .active_high(pol), .fault(fault));
  // Clock source
  initial begin
    forever #12.5 pclk = ~pclk;
  end
  // Verdict and end of run
  task automatic finish_test;
    if (num_errors == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Compare one word
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
      if (k > 50) begin
        num_errors++;
        finish_test();
      end
    end while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 0; penable <= 0;
  endtask
  // Count alarm events over a span of cycles
  task automatic count_alarms(input int cyc);
    n = 0;
    repeat (cyc) begin
      @(posedge pclk);
      if (alarm_event === 1'b1) n++;
    end
  endtask
  // Load 23:59:59 and a date, poll for midnight, compare the new date
  task automatic midnight(input logic [31:0] d, input logic [31:0] exp);
    int t;
    apb(1, 8'h14, 32'h0023_5959);
    apb(1, 8'h18, d);
    t = 0;
    do begin
      apb(0, 8'h14, 0);
      t++;
    end while (q[7:0] === 8'h59 && t < 100);
    if (t >= 100) begin
      num_errors++;
      finish_test();
    end
    chk(q, 32'h0000_0000);
    apb(0, 8'h18, 0); chk(q, exp);
  endtask
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1;
    apb(0, 8'h0C, 0); chk(q, 32'h0000_3FFF);
    apb(0, 8'h18, 0); chk(q, 32'h0001_0106);
    apb(0, 8'h28, 0); chk({err, q[30:0]}, 32'h8000_0000);
    // Alarm compare written while the alarm is off
    apb(1, 8'h1C, 32'h0012_3456);
    apb(0, 8'h1C, 0); chk(q, 32'h0012_3456);
    // Rollover at end of 2099, then leap and plain February
    apb(1, 8'h08, 32'h0000_0003);
    apb(1, 8'h0C, 32'h0000_0000);
    apb(1, 8'h00, 32'h0000_8000);
    midnight(32'h9912_3106, 32'h0001_0100);
    midnight(32'h2402_2803, 32'h2402_2904);
    midnight(32'h2302_2802, 32'h2303_0103);
    // One repeat without chime gives two alarms, then disables itself
    apb(1, 8'h04, 32'h0000_8001);
    count_alarms(200); chk(n, 2);
    apb(0, 8'h04, 0); chk(q, 32'h0000_0000);
    // Periodic power cycle: stability 3, sample 2
    apb(1, 8'h10, 32'h0000_0203);
    apb(1, 8'h00, 32'h0000_86B0);
    apb(1, 8'h04, 32'h0000_C000);
    p = 0;
    while (alarm_event !== 1'b1 && p < 100) begin
      @(posedge pclk);
      p++;
    end
    if (p >= 100) begin
      num_errors++;
      finish_test();
    end
    n = 0; g = 0;
    repeat (12) begin
      @(posedge pclk);
      if (rtc_pin === 1'b1) n++;
      if (sample_gate === 1'b1) g++;
    end
    chk(n, 5);
    chk(g, 2);
    count_alarms(100); chk(n > 2, 1);
    // Active-low idle level
    apb(1, 8'h04, 32'h0000_0000);
    repeat (20) @(posedge pclk);
    pol <= 0;
    apb(1, 8'h00, 32'h0000_84B0);
    repeat (3) @(posedge pclk);
    chk({rtc_pin_en, rtc_pin, fault}, 3'b110);
    // Stability FFh holds control active with power control off
    apb(1, 8'h10, 32'h0000_00FF);
    apb(1, 8'h00, 32'h0000_80B0);
    repeat (3) @(posedge pclk);
    chk({rtc_pin_en, rtc_pin}, 2'b10);
    // Reference level on the pin: crystal high, then RC low
    apb(1, 8'h00, 32'h0000_80A0);
    apb(1, 8'h08, 32'h0000_0000);
    xo <= 1'b1;
    repeat (3) @(posedge pclk);
    chk(rtc_pin, 1);
    apb(1, 8'h08, 32'h0000_0001);
    repeat (3) @(posedge pclk);
    chk(rtc_pin, 0);
    finish_test();
  end
endmodule
